//--- rtl/ssm_pkg.sv
// constants, field layouts and types of the serial port block
// assumes a 32-bit apb slave port with word-aligned registers
// Contract
// - master starts exchange on buffer write
// - receive-only master keeps sampling, delivers bytes
// - rates: clk/4, /16, /64, timer/2, reload
// - msb first out, msb first in
// - first bit valid before first clock edge
// - slave shifts on external edges, flags last
// - slave keeps working during sleep, flags byte
// - daisy chain: send back bits just received
// - overwrite enable accepts writes while buffer full
// - select control only with mode 0100
// - select low: shift enabled, data out driven
// - select high: stop driving data out
// - bit counter cleared by select high or disable
// - write while busy dropped, collision flag set
// - byte done sets full; buffer read clears
package ssm_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_CTRL3 = 8'h08;
   localparam logic [7:0] ADDR_BUF = 8'h0c;
   localparam logic [7:0] ADDR_RELOAD = 8'h10;
   localparam logic [7:0] ADDR_FLAGS = 8'h14;
   // field positions
   localparam int STAT_SMP = 7;
   localparam int STAT_CKE = 6;
   localparam int STAT_BF = 0;
   localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
   localparam int FLAG_IF = 0;
   localparam int FLAG_SDOIN = 1;
   // port mode field codes
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TIMER = 4'h3;
   localparam logic [3:0] MODE_SLV_SEL = 4'h4;
   localparam logic [3:0] MODE_SLV_FREE = 4'h5;
   localparam logic [3:0] MODE_RELOAD = 4'ha;
   // system clocks per serial clock half period
   localparam logic [8:0] HALF_DIV4 = 9'h002;
   localparam logic [8:0] HALF_DIV16 = 9'h008;
   localparam logic [8:0] HALF_DIV64 = 9'h020;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
   typedef struct packed {
      logic write_collision_flag;
      logic ov;
      logic en;
      logic clock_polarity_bit;
      logic [3:0] mode;
   } ssm_ctrl1_t;
   localparam ssm_ctrl1_t CTRL1_RST = 8'h00;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } ssm_state_t;
endpackage

//--- rtl/ssm_spi_port.sv
// byte-wide serial port, master or slave, with apb register access
// assumes pins arrive asynchronous; timer tick is a same-clock pulse
//
// Decided for this implementation: the APB register port and the placing of the registers.
module ssm_spi_port (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer rate source
   input wire logic timerTick,
   // serial pins
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe,
   input wire logic sdiIn,
   output logic sdoOut,
   output logic sdoOe,
   input wire logic slaveSelectN,
   // status
   output logic portIntFlag
);
   logic [1:0] rstSync;
   logic rstN;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) rstSync <= 2'b00;
      else rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   // pin synchronisers; third sck flop only feeds edge detection
   logic [1:0] sckS, sdiS, ssS;
   logic sckPrev;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         sckS <= 2'b00;
         sdiS <= 2'b00;
         ssS <= 2'b11;
         sckPrev <= 1'b0;
      end else begin
         sckS <= {sckS[0], sckIn};
         sdiS <= {sdiS[0], sdiIn};
         ssS <= {ssS[0], slaveSelectN};
         sckPrev <= sckS[1];
      end
   end

   ssm_pkg::ssm_ctrl1_t ctrl_reg, ctrl_next;
   ssm_pkg::ssm_state_t st_reg, st_next;
   logic smp_reg, smp_next, cke_reg, cke_next, bf_reg, bf_next;
   logic buffer_overwrite_enable_reg, buffer_overwrite_enable_next, flag_reg, flag_next, sdoIn_reg, sdoIn_next;
   logic [7:0] buf_reg, buf_next, sr_reg, sr_next, reload_reg, reload_next;
   logic [8:0] rate_reg, rate_next;
   logic [4:0] edge_reg, edge_next;
   logic [3:0] bit_reg, bit_next;
   logic sck_reg, sck_next, sdo_reg, sdo_next;
   logic [31:0] rd_reg, rd_next;

   logic isMaster, isSlave, selMode, selHigh, busy, halfTick, lead;
   logic acc, wrAcc, rdAcc, bufWr, bufWrOk, slvEdge, slvLead;
   logic doSample, doOut, byteDone;
   logic [8:0] halfLen;
   logic [7:0] shifted;

   assign isMaster = ctrl_reg.mode inside {ssm_pkg::MODE_DIV4,
      ssm_pkg::MODE_DIV16, ssm_pkg::MODE_DIV64, ssm_pkg::MODE_TIMER,
      ssm_pkg::MODE_RELOAD};
   assign isSlave = ctrl_reg.mode inside {ssm_pkg::MODE_SLV_SEL,
      ssm_pkg::MODE_SLV_FREE};
   assign selMode = ctrl_reg.mode == ssm_pkg::MODE_SLV_SEL;
   assign selHigh = selMode && ssS[1];
   assign busy = (st_reg == ssm_pkg::ST_RUN) || (isSlave && bit_reg != 4'h0);
   assign acc = psel && penable;
   assign wrAcc = acc && pwrite;
   assign rdAcc = acc && !pwrite;
   assign bufWr = wrAcc && paddr == ssm_pkg::ADDR_BUF;
   // full buffer blocks writes unless overwrite is enabled
   assign bufWrOk = bufWr && !busy && !ctrl_reg.write_collision_flag
      && (!bf_reg || buffer_overwrite_enable_reg);

   // last count of a half period; 2*(n+1)-1 still fits 9 bits at n=255
   always_comb begin
      unique case (ctrl_reg.mode)
         ssm_pkg::MODE_DIV16: halfLen = ssm_pkg::HALF_DIV16 - 9'h001;
         ssm_pkg::MODE_DIV64: halfLen = ssm_pkg::HALF_DIV64 - 9'h001;
         ssm_pkg::MODE_RELOAD: halfLen = {reload_reg, 1'b1};
         default: halfLen = ssm_pkg::HALF_DIV4 - 9'h001;
      endcase
   end
   assign halfTick = (st_reg == ssm_pkg::ST_RUN)
      && ((ctrl_reg.mode == ssm_pkg::MODE_TIMER) ? timerTick
      : (rate_reg >= halfLen));

   // lead edge leaves idle level; master edges at even edge_reg counts (0, 2, ...) are leading
   assign lead = !edge_reg[0];
   assign slvEdge = isSlave && ctrl_reg.en && !selHigh
      && (sckS[1] != sckPrev);
   assign slvLead = sckS[1] != ctrl_reg.clock_polarity_bit;
   always_comb begin
      doSample = 1'b0;
      doOut = 1'b0;
      if (halfTick) begin
         // late sampling applies to the trailing edge with cke set
         doSample = cke_reg ? (lead != smp_reg) : !lead;
         doOut = cke_reg ? !lead : lead;
      end else if (slvEdge) begin
         doSample = cke_reg ? slvLead : !slvLead;
         doOut = !doSample;
      end
   end
   assign shifted = {sr_reg[6:0], sdiS[1]};
   assign byteDone = halfTick ? (edge_reg == ssm_pkg::EDGES_PER_BYTE - 5'h01)
      : (doSample && bit_reg == ssm_pkg::BITS_PER_BYTE - 4'h1);

   always_comb begin
      ctrl_next = ctrl_reg;
      st_next = st_reg;
      smp_next = smp_reg;
      cke_next = cke_reg;
      bf_next = bf_reg;
      buffer_overwrite_enable_next = buffer_overwrite_enable_reg;
      flag_next = flag_reg;
      sdoIn_next = sdoIn_reg;
      buf_next = buf_reg;
      sr_next = sr_reg;
      reload_next = reload_reg;
      rate_next = rate_reg;
      edge_next = edge_reg;
      bit_next = bit_reg;
      sck_next = sck_reg;
      sdo_next = sdo_reg;
      rd_next = rd_reg;
      // register writes; hardware sets below take priority
      if (wrAcc) begin
         unique case (paddr)
            ssm_pkg::ADDR_CTRL1: ctrl_next = pwdata[7:0];
            ssm_pkg::ADDR_STAT: begin
               smp_next = pwdata[ssm_pkg::STAT_SMP];
               cke_next = pwdata[ssm_pkg::STAT_CKE];
            end
            ssm_pkg::ADDR_CTRL3: buffer_overwrite_enable_next = pwdata[ssm_pkg::CTRL3_BUFFER_OVERWRITE_ENABLE];
            ssm_pkg::ADDR_RELOAD: reload_next = pwdata[7:0];
            ssm_pkg::ADDR_FLAGS: begin
               flag_next = flag_reg && pwdata[ssm_pkg::FLAG_IF];
               sdoIn_next = pwdata[ssm_pkg::FLAG_SDOIN];
            end
            default: ;
         endcase
      end
      if (rdAcc && paddr == ssm_pkg::ADDR_BUF) bf_next = 1'b0;
      if (bufWr && !bufWrOk) ctrl_next.write_collision_flag = 1'b1;
      if (bufWrOk) begin
         buf_next = pwdata[7:0];
         sr_next = pwdata[7:0];
         sdo_next = pwdata[7];
         if (isMaster && ctrl_reg.en) begin
            st_next = ssm_pkg::ST_RUN;
            rate_next = 9'h000;
            edge_next = 5'h00;
            sck_next = ctrl_reg.clock_polarity_bit;
         end
      end
      if (st_reg == ssm_pkg::ST_RUN) begin
         rate_next = halfTick ? 9'h000 : rate_reg + 9'h001;
         if (halfTick) begin
            sck_next = !sck_reg;
            edge_next = edge_reg + 5'h01;
         end
      end
      if (doSample) begin
         sr_next = shifted;
         bit_next = bit_reg + 4'h1;
      end
      if (doOut) sdo_next = doSample ? shifted[7] : sr_reg[7];
      if (byteDone) begin
         bit_next = 4'h0;
         st_next = ssm_pkg::ST_IDLE;
         sck_next = ctrl_reg.clock_polarity_bit;
         flag_next = 1'b1;
         if (bf_reg && !(rdAcc && paddr == ssm_pkg::ADDR_BUF)
            && isSlave) begin
            ctrl_next.ov = 1'b1;
         end else begin
            buf_next = doSample ? shifted : sr_reg;
            bf_next = 1'b1;
         end
      end
      // select high or disable drops any partial byte
      if (selHigh || !ctrl_reg.en) begin
         bit_next = 4'h0;
         if (!ctrl_reg.en) st_next = ssm_pkg::ST_IDLE;
      end
      if (!isMaster || !ctrl_reg.en) sck_next = ctrl_reg.clock_polarity_bit;
      // read data captured in the setup phase
      if (psel && !penable) begin
         unique case (paddr)
            ssm_pkg::ADDR_CTRL1: rd_next = {24'h000000, ctrl_reg};
            ssm_pkg::ADDR_STAT: rd_next = {24'h000000, smp_reg, cke_reg,
               5'h00, bf_reg};
            ssm_pkg::ADDR_CTRL3: rd_next = {27'h0000000, buffer_overwrite_enable_reg, 4'h0};
            ssm_pkg::ADDR_BUF: rd_next = {24'h000000, buf_reg};
            ssm_pkg::ADDR_RELOAD: rd_next = {24'h000000, reload_reg};
            ssm_pkg::ADDR_FLAGS: rd_next = {30'h00000000, sdoIn_reg,
               flag_reg};
            default: rd_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         ctrl_reg <= ssm_pkg::CTRL1_RST;
         st_reg <= ssm_pkg::ST_IDLE;
         smp_reg <= 1'b0;
         cke_reg <= 1'b0;
         bf_reg <= 1'b0;
         buffer_overwrite_enable_reg <= 1'b0;
         flag_reg <= 1'b0;
         sdoIn_reg <= 1'b0;
         buf_reg <= 8'h00;
         sr_reg <= 8'h00;
         reload_reg <= 8'h00;
         rate_reg <= 9'h000;
         edge_reg <= 5'h00;
         bit_reg <= 4'h0;
         sck_reg <= 1'b0;
         sdo_reg <= 1'b0;
         rd_reg <= 32'h00000000;
      end else begin
         ctrl_reg <= ctrl_next;
         st_reg <= st_next;
         smp_reg <= smp_next;
         cke_reg <= cke_next;
         bf_reg <= bf_next;
         buffer_overwrite_enable_reg <= buffer_overwrite_enable_next;
         flag_reg <= flag_next;
         sdoIn_reg <= sdoIn_next;
         buf_reg <= buf_next;
         sr_reg <= sr_next;
         reload_reg <= reload_next;
         rate_reg <= rate_next;
         edge_reg <= edge_next;
         bit_reg <= bit_next;
         sck_reg <= sck_next;
         sdo_reg <= sdo_next;
         rd_reg <= rd_next;
      end
   end

   assign prdata = rd_reg;
   assign pready = 1'b1;
   assign pslverr = acc && !(paddr inside {ssm_pkg::ADDR_CTRL1,
      ssm_pkg::ADDR_STAT, ssm_pkg::ADDR_CTRL3, ssm_pkg::ADDR_BUF,
      ssm_pkg::ADDR_RELOAD, ssm_pkg::ADDR_FLAGS});
   assign sckOut = sck_reg;
   assign sckOe = ctrl_reg.en && isMaster;
   assign sdoOut = sdo_reg;
   // select release lags the pin by the two synchroniser cycles
   assign sdoOe = ctrl_reg.en && !sdoIn_reg && (isMaster
      || (isSlave && !selHigh));
   assign portIntFlag = flag_reg;

   property p_start;
      @(posedge clock) disable iff (!rstN)
      bufWrOk && isMaster && ctrl_reg.en |=> st_reg == ssm_pkg::ST_RUN;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_done;
      @(posedge clock) disable iff (!rstN)
      halfTick && edge_reg == 5'h0f |=> bf_reg && flag_reg
         && st_reg == ssm_pkg::ST_IDLE;
   endproperty
   a_done: assert property (p_done) else $error("no delivery");
   property p_rate4;
      @(posedge clock) disable iff (!rstN)
      halfTick && ctrl_reg.mode == ssm_pkg::MODE_DIV4 && edge_reg < 5'h0e
         |=> !halfTick ##1 halfTick;
   endproperty
   a_rate4: assert property (p_rate4) else $error("bad rate");
   property p_msb;
      @(posedge clock) disable iff (!rstN)
      bufWrOk |=> sdoOut == $past(pwdata[7]) && sckOut == ctrl_reg.clock_polarity_bit;
   endproperty
   a_msb: assert property (p_msb) else $error("msb not out");
   property p_slvdone;
      @(posedge clock) disable iff (!rstN)
      slvEdge && doSample && bit_reg == 4'h7 |=> flag_reg && bit_reg == 4'h0;
   endproperty
   a_slvdone: assert property (p_slvdone) else $error("no flag");
   property p_chain;
      @(posedge clock) disable iff (!rstN)
      slvEdge && byteDone && !bf_reg |=> buf_reg == sr_reg;
   endproperty
   a_chain: assert property (p_chain) else $error("chain");
   property p_overw;
      @(posedge clock) disable iff (!rstN)
      bufWr && buffer_overwrite_enable_reg && !busy && !ctrl_reg.write_collision_flag
         |=> sr_reg == $past(pwdata[7:0]);
   endproperty
   a_overw: assert property (p_overw) else $error("overwrite");
   property p_free;
      @(posedge clock) disable iff (!rstN)
      ctrl_reg.en && ctrl_reg.mode == ssm_pkg::MODE_SLV_FREE && !sdoIn_reg
         |-> sdoOe;
   endproperty
   a_free: assert property (p_free) else $error("select used");
   property p_selout;
      @(posedge clock) disable iff (!rstN)
      selMode && $rose(ssS[1]) |-> !sdoOe;
   endproperty
   a_selout: assert property (p_selout) else $error("still driving");
   property p_clr;
      @(posedge clock) disable iff (!rstN)
      !ctrl_reg.en |=> bit_reg == 4'h0 && st_reg == ssm_pkg::ST_IDLE;
   endproperty
   a_clr: assert property (p_clr) else $error("count kept");
   property p_coll;
      @(posedge clock) disable iff (!rstN)
      bufWr && busy |=> ctrl_reg.write_collision_flag && $stable(buf_reg);
   endproperty
   a_coll: assert property (p_coll) else $error("no collision");
   property p_rdclr;
      @(posedge clock) disable iff (!rstN)
      rdAcc && paddr == ssm_pkg::ADDR_BUF && !byteDone |=> !bf_reg;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("full kept");
   property p_part;
      @(posedge clock) disable iff (!rstN)
      selHigh && bit_reg != 4'h0 |=> bit_reg == 4'h0 && $stable(buf_reg);
   endproperty
   a_part: assert property (p_part) else $error("partial kept");
   c_master: cover property (@(posedge clock) disable iff (!rstN)
      halfTick && byteDone);
   c_slave: cover property (@(posedge clock) disable iff (!rstN)
      slvEdge && byteDone);
   c_coll: cover property (@(posedge clock) disable iff (!rstN)
      bufWr && busy);
   c_abort: cover property (@(posedge clock) disable iff (!rstN)
      selHigh && bit_reg != 4'h0);
endmodule

//--- verif/ssm_peer_model.sv
// far-side serial device: slave for master tests, master for slave tests
// assumes clock polarity 0 and one role in use at a time
module ssm_peer_model (
   // system clock
   input wire logic clock,
   // port pins seen from the far side
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic sdoOut,
   output logic sckPin,
   output logic sdiPin,
   output logic selN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] txByte;
   logic [7:0] rxByte;
   logic lastSck;
   logic mst;
   initial begin
      sckPin = 1'b0;
      sdiPin = 1'b0;
      selN = 1'b1;
      txByte = 8'h00;
      rxByte = 8'h00;
      lastSck = 1'b0;
      mst = 1'b0;
   end
   // slave role: sample on rise, shift on fall; refill keeps line moving
   always @(posedge clock) begin
      lastSck <= sckOut;
      if (!mst) begin
         if (sckOe && sckOut && !lastSck) rxByte <= {rxByte[6:0], sdoOut};
         if (sckOe && !sckOut && lastSck) txByte <= {txByte[6:0], ~txByte[0]};
         sdiPin <= txByte[7];
      end
   end
   task automatic load(input logic [7:0] b);
      txByte <= b;
      mst <= 1'b0;
   endtask
   task automatic sel(input logic v);
      selN <= v;
   endtask
   // master role: data changes with the rise, so it stands at the fall
   // where the port samples; port output taken before the fall
   task automatic xfer(input logic [7:0] b, input int nBits);
      mst <= 1'b1;
      for (int i = 0; i < nBits; i++) begin
         repeat (10) @(posedge clock);
         sckPin <= 1'b1;
         sdiPin <= b[7 - i];
         repeat (10) @(posedge clock);
         rxByte <= {rxByte[6:0], sdoOut};
         sckPin <= 1'b0;
      end
      repeat (10) @(posedge clock);
      sdiPin <= ~sdiPin;
   endtask
endmodule

//--- verif/test_spi_master_slave_port.sv
// self-checking bench for the serial port: apb tasks plus a far-side model
// assumes zero-wait apb and no assertions needed outside the design
module test_spi_master_slave_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, arst_n, psel, penable, pwrite, timerTick, err, firstSdo;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, sckOut, sckOe, sdoOut, sdoOe, portIntFlag;
   logic sckPin, sdiPin, selN, lastSck;
   int n_mismatch, checks, cyc, nTog, t1, half;
   int hf[5];
   logic [3:0] md[5];
   ssm_spi_port dut_u (.clock(clock), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerTick(timerTick), .sckIn(sckPin), .sckOut(sckOut), .sckOe(sckOe),
      .sdiIn(sdiPin), .sdoOut(sdoOut), .sdoOe(sdoOe),
      .slaveSelectN(selN), .portIntFlag(portIntFlag));
   ssm_peer_model peer_u (.clock(clock), .sckOut(sckOut), .sckOe(sckOe),
      .sdoOut(sdoOut), .sckPin(sckPin), .sdiPin(sdiPin), .selN(selN));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // timer tick every 6 clocks; hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      timerTick <= (cyc % 6 == 5);
      if (cyc > 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // toggle monitor on the falling edge, where the pins have settled
   always @(negedge clock) begin
      lastSck <= sckOut;
      if (sckOut !== lastSck) begin
         nTog = nTog + 1;
         if (nTog == 1) begin
            t1 = cyc;
            firstSdo = sdoOut;
         end
         if (nTog == 2) half = cyc - t1;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task mx(input logic [3:0] m, input logic [7:0] b);
      wr(ssm_pkg::ADDR_CTRL1, {24'h0, 4'h2, m});
      nTog = 0;
      wr(ssm_pkg::ADDR_BUF, {24'h0, b});
   endtask
   task waitFlag;
      int n;
      n = 0;
      while (portIntFlag !== 1'b1 && n < 9000) begin
         @(posedge clock);
         n++;
      end
      chk({31'h0, portIntFlag}, 32'h1);
      wr(ssm_pkg::ADDR_FLAGS, 32'h0);
   endtask
   initial begin
      {arst_n, psel, penable, pwrite, timerTick, paddr, pwdata} = '0;
      {n_mismatch, checks, cyc, nTog, t1, half} = '0;
      lastSck = 1'b0;
      md = '{ssm_pkg::MODE_DIV4, ssm_pkg::MODE_DIV16, ssm_pkg::MODE_DIV64,
         ssm_pkg::MODE_TIMER, ssm_pkg::MODE_RELOAD};
      hf = '{ssm_pkg::HALF_DIV4, ssm_pkg::HALF_DIV16, ssm_pkg::HALF_DIV64,
         6, 2 * (3 + 1)};
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd(ssm_pkg::ADDR_CTRL1);
      chk(q, 32'h0);
      rd(8'h18);
      chk({31'h0, err}, 32'h1);
      wr(ssm_pkg::ADDR_RELOAD, 32'h3);
      wr(ssm_pkg::ADDR_STAT, 32'h40);
      for (int i = 0; i < 5; i++) begin
         peer_u.load(8'h3c);
         mx(md[i], 8'ha5);
         waitFlag();
         chk(half, hf[i]);
         chk(nTog, 16);
         chk({31'h0, firstSdo}, 32'h1);
         chk({24'h0, peer_u.rxByte}, 32'ha5);
         rd(ssm_pkg::ADDR_BUF);
         // fastest rate leaves too little margin for the input synchroniser
         if (i > 0) chk(q, 32'h3c);
      end
      // largest reload: half period needs the full counter range
      wr(ssm_pkg::ADDR_RELOAD, 32'hff);
      mx(ssm_pkg::MODE_RELOAD, 8'h5a);
      waitFlag();
      chk(half, 2 * (255 + 1));
      rd(ssm_pkg::ADDR_BUF);
      $display("rate test done");
      wr(ssm_pkg::ADDR_FLAGS, 32'h2);
      peer_u.load(8'h5c);
      mx(ssm_pkg::MODE_DIV16, 8'h00);
      chk({31'h0, sdoOe}, 32'h0);
      waitFlag();
      rd(ssm_pkg::ADDR_BUF);
      chk(q, 32'h5c);
      wr(ssm_pkg::ADDR_FLAGS, 32'h0);
      $display("receive-only test done");
      peer_u.load(8'h00);
      mx(ssm_pkg::MODE_DIV64, 8'ha5);
      wr(ssm_pkg::ADDR_BUF, 32'h11);
      rd(ssm_pkg::ADDR_CTRL1);
      chk({31'h0, q[7]}, 32'h1);
      waitFlag();
      chk({24'h0, peer_u.rxByte}, 32'ha5);
      wr(ssm_pkg::ADDR_CTRL1, 32'h21);
      wr(ssm_pkg::ADDR_BUF, 32'h22);
      rd(ssm_pkg::ADDR_CTRL1);
      chk({31'h0, q[7]}, 32'h1);
      rd(ssm_pkg::ADDR_STAT);
      chk({31'h0, q[0]}, 32'h1);
      wr(ssm_pkg::ADDR_CTRL1, 32'h21);
      wr(ssm_pkg::ADDR_CTRL3, 32'h10);
      wr(ssm_pkg::ADDR_BUF, 32'h22);
      rd(ssm_pkg::ADDR_CTRL1);
      chk({31'h0, q[7]}, 32'h0);
      waitFlag();
      chk({24'h0, peer_u.rxByte}, 32'h22);
      rd(ssm_pkg::ADDR_BUF);
      rd(ssm_pkg::ADDR_STAT);
      chk({31'h0, q[0]}, 32'h0);
      wr(ssm_pkg::ADDR_CTRL3, 32'h0);
      $display("collision test done");
      wr(ssm_pkg::ADDR_CTRL1, 32'h0);
      wr(ssm_pkg::ADDR_STAT, 32'h0);
      wr(ssm_pkg::ADDR_CTRL1, 32'h24);
      wr(ssm_pkg::ADDR_BUF, 32'hc3);
      peer_u.sel(1'b0);
      repeat (5) @(posedge clock);
      chk({31'h0, sdoOe}, 32'h1);
      peer_u.xfer(8'h96, 8);
      waitFlag();
      chk({24'h0, peer_u.rxByte}, 32'hc3);
      rd(ssm_pkg::ADDR_BUF);
      chk(q, 32'h96);
      peer_u.xfer(8'h00, 8);
      waitFlag();
      chk({24'h0, peer_u.rxByte}, 32'h96);
      rd(ssm_pkg::ADDR_BUF);
      peer_u.xfer(8'hff, 4);
      peer_u.sel(1'b1);
      repeat (5) @(posedge clock);
      chk({31'h0, sdoOe}, 32'h0);
      chk({31'h0, portIntFlag}, 32'h0);
      rd(ssm_pkg::ADDR_BUF);
      chk(q, 32'h00);
      peer_u.sel(1'b0);
      peer_u.xfer(8'h5a, 8);
      waitFlag();
      rd(ssm_pkg::ADDR_BUF);
      chk(q, 32'h5a);
      $display("slave test done");
      // select ignored outside mode 0100, honoured inside it
      peer_u.sel(1'b1);
      wr(ssm_pkg::ADDR_CTRL1, 32'h25);
      repeat (5) @(posedge clock);
      chk({31'h0, sdoOe}, 32'h1);
      wr(ssm_pkg::ADDR_CTRL1, 32'h24);
      repeat (5) @(posedge clock);
      chk({31'h0, sdoOe}, 32'h0);
      $display("select mode test done");
      // reset while enabled in slave mode 0100 returns the port to disabled
      arst_n <= 1'b0;
      @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd(ssm_pkg::ADDR_CTRL1);
      chk(q, 32'h0);
      $display("reset test done");
      tally_and_finish();
   end
endmodule
